/* File: design/cpps_consts.svh */
`ifndef CPPS_CONSTS_SVH
`define CPPS_CONSTS_SVH
// Register addresses
`define CPPS_ADR_CHG 8'h00
`define CPPS_ADR_CTL 8'h01
`define CPPS_ADR_SYS 8'h02
`define CPPS_ADR_STATE 8'h03
`define CPPS_ADR_SEQ 8'h05
// Field positions
`define CPPS_TRICKLE_BIT 6
`define CPPS_CEN2_BIT 0
`define CPPS_LIM_LSB 1
`define CPPS_THBAT_BIT 4
`define CPPS_LOAD_SWITCH_AUTO_CTRL_BIT 3
`define CPPS_OVL_BIT 0
`define CPPS_POK_BIT 1
`define CPPS_TOUT_BIT 3
`define CPPS_BATTERY_ABSENT_FLAG_BIT 5
`define CPPS_VBATH_BIT 6
`define CPPS_GDBAT_BIT 7
// Reset values
`define CPPS_RST_CHG 8'h19
`define CPPS_RST_CTL 8'h10
`define CPPS_RST_SYS 8'h00
// Timing
`define CPPS_CLK_MHZ 50
`define CPPS_WEAK_MIN 40
`define CPPS_WEAK_CYC (64'd60000000 * `CPPS_WEAK_MIN * `CPPS_CLK_MHZ)
`define CPPS_TRK_MIN 60
`define CPPS_TRK_CYC (64'd60000000 * `CPPS_TRK_MIN * `CPPS_CLK_MHZ)
`define CPPS_FORCE_MS 10
`define CPPS_FORCE_CYC (32'd1000 * `CPPS_FORCE_MS * `CPPS_CLK_MHZ)
`endif

/* File: design/cpps_pkg.sv */
package cpps_pkg;
	// Charge state codes as shown to software
	typedef enum logic [3:0] {
		CPPS_DEFAULT = 4'h0,
		CPPS_FORCED = 4'h1,
		CPPS_TRICKLE = 4'h2,
		CPPS_QUICK = 4'h3,
		CPPS_NOBATT = 4'h8,
		CPPS_ERR1 = 4'h9
	} cpps_state_e;
	// Sampled comparator results
	typedef struct packed {
		logic vin_ok;
		logic vin_hl;
		logic vbat_start;
		logic vbat_qc;
		logic vbat_ov;
		logic vbat_weak;
		logic vbat_good;
		logic th_con;
		logic bat_short;
	} cpps_cmp_s;
	// Power path commands
	typedef struct packed {
		logic [2:0] lim_sel;
		logic freeze;
		logic chg_on;
		logic trickle_02c;
		logic share;
	} cpps_path_s;
	// Port kinds after detection
	typedef enum logic [1:0] {
		CPPS_PORT_SDP,
		CPPS_PORT_CHG,
		CPPS_PORT_DIV
	} cpps_port_e;
endpackage

/* File: design/cpps_sync.sv */
`timescale 1ns/10ps
module cpps_sync import cpps_pkg::*; #(
	parameter int W = 9
) (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} cpps_sy_s;
	cpps_sy_s st_q, st_d;
	// Two-stage sampler, first stage read only by second
	always_comb begin
		st_d.s1 = async_i;
		st_d.s2 = st_q.s1;
	end
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign sync_o = st_q.s2;
endmodule

/* File: design/cpps_timer.sv */
`timescale 1ns/10ps
module cpps_timer import cpps_pkg::*; #(
	parameter int W = 40
) (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic run_i,
	input wire logic clear_i,
	input wire logic [W-1:0] limit_i,
	output logic done_o
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic done;
	} cpps_tm_s;
	cpps_tm_s st_q, st_d;
	// Counts while run, sticky done until clear
	always_comb begin
		st_d = st_q;
		if (clear_i) begin
			st_d = '0;
		end else if (run_i && !st_q.done) begin
			st_d.cnt = st_q.cnt + W'(1);
			if (st_q.cnt + W'(1) >= limit_i) begin
				st_d.done = 1'b1;
			end
		end
	end
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign done_o = st_q.done;
endmodule

/* File: design/cpps_top.sv */
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "cpps_consts.svh"
//Contract
// R1: Gate held high during port detection or dead battery provision.
// R2: Software enables or disables automatic gate control in register 02H.
// R3: After detection, gate enabled, low battery turns load switch off.
// R4: Input limit 100/500/1000/1500/1800 mA, unlimited or suspend selectable.
// R5: Charge current reduced when system plus charge reaches limit.
// R6: Input below overload threshold freezes current, sets 03H bit 0.
// R7: No battery charging while overload is active.
// R8: Power good low and path enabled only inside input window.
// R9: Thermistor detect off: battery connected only above start voltage.
// R10: Thermistor detect on: battery voltage or thermistor voltage shows connection.
// R11: Input applied with battery connected starts charging from default state.
// R12: Detect off, open battery attached late stays in default state; the code re-enters forced charge from default while charging is allowed.
// R13: Integrator must not enable thermistor detect wrongly nor charge without battery.
// R14: SDP dead battery provision runs weak timer; 40 min weak leads to suspend.
// R15: Charging port keeps provision while weak, redetects once battery good.
// R16: Divided port leaves gate while weak, drives low once good.
// R17: Forced charge first at trickle current from 00H bit 6.
// R18: Trickle below 3.0 V, quick charge once threshold reached.
// R19: Trickle timer starts on entry; expiry below threshold gives error 1.
// R20: Timer stops below start voltage or short; flag at 03H bit 5.
// R21: Host stops charging when battery absent flag reads one.
// R22: Overvoltage 4.35 V during trickle gives error 1.
// R23: Trickle current selectable 0.1C or 0.2C in 00H.
// R24: All comparator results sampled to the clock before use.
module cpps_top import cpps_pkg::*; #(
	parameter longint WEAK_CYC = `CPPS_WEAK_CYC,
	parameter longint TRK_CYC = `CPPS_TRK_CYC,
	parameter int FORCE_CYC = `CPPS_FORCE_CYC
) (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire cpps_cmp_s cmp_i,
	input wire logic usb_det_busy_i,
	input wire logic usb_det_done_i,
	input wire cpps_port_e port_kind_i,
	input wire logic charge_enable_n_i,
	output logic system_load_switch_gate_n_o,
	output logic input_power_good_n_o,
	output logic usb_redetect_o,
	output logic dbp_active_o,
	output cpps_path_s path_o,
	output cpps_state_e chg_state_o
);
	cpps_cmp_s cmp;
	logic weak_done, trk_done, force_done;

	typedef struct packed {
		logic [7:0] chg;
		logic [7:0] ctl;
		logic [7:0] sys;
		logic [7:0] rdata;
		cpps_state_e st;
		logic dbp;
		logic suspend;
		logic ovl;
		logic battery_absent_flag;
		logic gate_n;
		logic pok_n;
		logic redet;
		logic trk_run;
		logic div_good;
		cpps_path_s path;
	} cpps_top_s;
	cpps_top_s st_q, st_d;

	// Comparator sampling [R24]
	cpps_sync #(.W($bits(cpps_cmp_s))) u_sync (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.async_i(cmp_i),
		.sync_o(cmp)
	);

	// Weak battery timer, only on SDP provision [R14]
	cpps_timer #(.W(40)) u_weak (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.run_i(st_q.dbp && port_kind_i == CPPS_PORT_SDP && !cmp.vbat_good),
		.clear_i(!st_q.dbp),
		.limit_i(40'(WEAK_CYC)),
		.done_o(weak_done)
	);

	// Trickle timer, halted below start or on short [R19] [R20]
	cpps_timer #(.W(40)) u_trk (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.run_i(st_q.trk_run && cmp.vbat_start && !cmp.bat_short),
		.clear_i(st_q.st != CPPS_TRICKLE),
		.limit_i(40'(TRK_CYC)),
		.done_o(trk_done)
	);

	// Forced charge duration
	cpps_timer #(.W(32)) u_force (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.run_i(st_q.st == CPPS_FORCED),
		.clear_i(st_q.st != CPPS_FORCED),
		.limit_i(32'(FORCE_CYC)),
		.done_o(force_done)
	);

	// Battery presence decision
	function automatic logic bat_conn(input cpps_cmp_s c, input logic th_en);
		bat_conn = c.vbat_start || (th_en && c.th_con); // [R9] [R10]
	endfunction

	// Register address decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
		hit = (a == ref_a);
	endfunction

	logic pwr_ok, chg_allow, th_en, sg_auto;
	assign th_en = st_q.sys[`CPPS_THBAT_BIT];
	assign sg_auto = !st_q.sys[`CPPS_LOAD_SWITCH_AUTO_CTRL_BIT];
	assign pwr_ok = cmp.vin_ok;
	assign chg_allow = pwr_ok && !cmp.vin_hl && !st_q.suspend && !charge_enable_n_i
		&& !st_q.ctl[`CPPS_CEN2_BIT] && (st_q.ctl[3:1] != 3'h7);

	// Next-state logic
	always_comb begin
		st_d = st_q;
		st_d.redet = 1'b0;
		// Register writes
		if (reg_wr_i) begin
			if (hit(reg_addr_i, `CPPS_ADR_CHG)) begin
				st_d.chg = reg_wdata_i; // [R23]
			end
			if (hit(reg_addr_i, `CPPS_ADR_CTL)) begin
				st_d.ctl = reg_wdata_i; // [R4]
			end
			if (hit(reg_addr_i, `CPPS_ADR_SYS)) begin
				st_d.sys = reg_wdata_i; // [R2]
			end
		end
		// Register reads, data one cycle later
		st_d.rdata = 8'h00;
		if (reg_rd_i) begin
			if (hit(reg_addr_i, `CPPS_ADR_CHG)) begin
				st_d.rdata = st_q.chg;
			end else if (hit(reg_addr_i, `CPPS_ADR_CTL)) begin
				st_d.rdata = st_q.ctl;
			end else if (hit(reg_addr_i, `CPPS_ADR_SYS)) begin
				st_d.rdata = st_q.sys;
			end else if (hit(reg_addr_i, `CPPS_ADR_STATE)) begin
				st_d.rdata[`CPPS_OVL_BIT] = st_q.ovl;
				st_d.rdata[`CPPS_POK_BIT] = !st_q.pok_n;
				st_d.rdata[`CPPS_TOUT_BIT] = trk_done;
				st_d.rdata[`CPPS_BATTERY_ABSENT_FLAG_BIT] = st_q.battery_absent_flag;
				st_d.rdata[`CPPS_VBATH_BIT] = cmp.vbat_ov;
				st_d.rdata[`CPPS_GDBAT_BIT] = cmp.vbat_good;
			end else if (hit(reg_addr_i, `CPPS_ADR_SEQ)) begin
				st_d.rdata = {4'h0, st_q.st};
			end
		end
		// Overload status tracks sampled threshold [R6]
		st_d.ovl = cmp.vin_hl && pwr_ok;
		st_d.pok_n = !pwr_ok; // [R8]
		// Battery absent flag [R20]
		st_d.battery_absent_flag = !cmp.vbat_start || cmp.bat_short;
		// Dead battery provision entry on weak battery at detection
		if (usb_det_done_i && port_kind_i != CPPS_PORT_DIV && !cmp.vbat_good) begin
			st_d.dbp = 1'b1;
		end
		if (st_q.dbp && cmp.vbat_good) begin
			st_d.dbp = 1'b0;
			st_d.redet = 1'b1; // [R15]
		end
		// Divided port remembers a good battery once seen [R16]
		if (port_kind_i == CPPS_PORT_DIV && cmp.vbat_good) begin
			st_d.div_good = 1'b1;
		end
		if (weak_done && st_q.ctl[6:4] == 3'h1) begin
			st_d.suspend = 1'b1; // [R14]
		end
		if (!pwr_ok) begin
			st_d.suspend = 1'b0;
			st_d.dbp = 1'b0;
			st_d.div_good = 1'b0;
		end
		// Load switch gate
		if (usb_det_busy_i || st_q.dbp) begin
			st_d.gate_n = 1'b1; // [R1]
		end else if (!sg_auto) begin
			st_d.gate_n = 1'b0; // [R2]
		end else if (port_kind_i == CPPS_PORT_DIV && !cmp.vbat_good && !st_q.div_good) begin
			st_d.gate_n = st_q.gate_n; // [R16]
		end else if (port_kind_i == CPPS_PORT_DIV && cmp.vbat_good) begin
			st_d.gate_n = 1'b0; // [R16]
		end else begin
			st_d.gate_n = cmp.vbat_weak; // [R3]
		end
		// Charge sequencer
		case (st_q.st)
			CPPS_DEFAULT: begin
				if (chg_allow) begin
					st_d.st = CPPS_FORCED; // [R11] [R17]
				end
			end
			CPPS_FORCED: begin
				if (force_done) begin
					if (bat_conn(cmp, th_en)) begin
						st_d.st = cmp.vbat_qc ? CPPS_QUICK : CPPS_TRICKLE; // [R18]
					end else begin
						st_d.st = CPPS_DEFAULT; // [R12]
					end
				end
			end
			CPPS_TRICKLE: begin
				if (cmp.vbat_ov) begin
					st_d.st = CPPS_ERR1; // [R22]
				end else if (cmp.vbat_qc) begin
					st_d.st = CPPS_QUICK; // [R18]
				end else if (trk_done) begin
					st_d.st = CPPS_ERR1; // [R19]
				end
			end
			CPPS_QUICK: begin
				if (cmp.vbat_ov) begin
					st_d.st = CPPS_ERR1;
				end
			end
			CPPS_NOBATT, CPPS_ERR1: begin
			end
			default: begin
				st_d.st = CPPS_DEFAULT;
			end
		endcase
		if (!pwr_ok || charge_enable_n_i) begin
			st_d.st = CPPS_DEFAULT;
		end
		st_d.trk_run = (st_d.st == CPPS_TRICKLE); // [R19]
		// Power path commands
		// Suspend from the weak timer forces the suspend limit code
		st_d.path.lim_sel = st_q.suspend ? 3'h7 : st_q.ctl[3:1]; // [R4] [R14]
		st_d.path.freeze = cmp.vin_hl; // [R6]
		st_d.path.share = 1'b1; // [R5]
		st_d.path.chg_on = chg_allow && (st_d.st != CPPS_DEFAULT)
			&& (st_d.st != CPPS_ERR1); // [R7] [R8]
		st_d.path.trickle_02c = st_q.chg[`CPPS_TRICKLE_BIT]; // [R17] [R23]
	end

	// State register
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			st_q <= '0;
			st_q.chg <= `CPPS_RST_CHG;
			st_q.ctl <= `CPPS_RST_CTL;
			st_q.sys <= `CPPS_RST_SYS;
			st_q.st <= CPPS_DEFAULT;
			st_q.gate_n <= 1'b1;
			st_q.pok_n <= 1'b1;
			st_q.battery_absent_flag <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata_o = st_q.rdata;
	assign system_load_switch_gate_n_o = st_q.gate_n;
	assign input_power_good_n_o = st_q.pok_n;
	assign usb_redetect_o = st_q.redet;
	assign dbp_active_o = st_q.dbp;
	assign path_o = st_q.path;
	assign chg_state_o = st_q.st;

	// Checks
	property p_gate_det;
		@(posedge clock_i) disable iff (sys_rst_i)
		usb_det_busy_i |=> system_load_switch_gate_n_o;
	endproperty
	a_gate_det: assert property (p_gate_det) else $error("gate low during detection"); // [R1]
	property p_sg_off;
		@(posedge clock_i) disable iff (sys_rst_i)
		(!usb_det_busy_i && !st_q.dbp && st_q.sys[3]) |=> !system_load_switch_gate_n_o;
	endproperty
	a_sg_off: assert property (p_sg_off) else $error("gate not low when disabled"); // [R2]
	property p_ovl;
		@(posedge clock_i) disable iff (sys_rst_i)
		cmp.vin_hl |=> path_o.freeze && !path_o.chg_on;
	endproperty
	a_ovl: assert property (p_ovl) else $error("overload not handled"); // [R7]
	property p_pok;
		@(posedge clock_i) disable iff (sys_rst_i)
		!cmp.vin_ok |=> input_power_good_n_o;
	endproperty
	a_pok: assert property (p_pok) else $error("power good wrongly low"); // [R8]
	property p_ov_err;
		@(posedge clock_i) disable iff (sys_rst_i)
		(chg_state_o == CPPS_TRICKLE && cmp.vbat_ov && cmp.vin_ok && !charge_enable_n_i)
		|=> chg_state_o == CPPS_ERR1;
	endproperty
	a_ov_err: assert property (p_ov_err) else $error("no error on overvoltage"); // [R22]
	property p_battery_absent_flag;
		@(posedge clock_i) disable iff (sys_rst_i)
		!cmp.vbat_start |=> st_q.battery_absent_flag;
	endproperty
	a_battery_absent_flag: assert property (p_battery_absent_flag) else $error("absent flag missing"); // [R20]
	property p_redet;
		@(posedge clock_i) disable iff (sys_rst_i)
		(st_q.dbp && cmp.vbat_good) |=> usb_redetect_o && !dbp_active_o;
	endproperty
	a_redet: assert property (p_redet) else $error("no redetect"); // [R15]
	property p_rd;
		@(posedge clock_i) disable iff (sys_rst_i)
		(reg_rd_i && reg_addr_i == 8'h05) |=> reg_rdata_o == {4'h0, $past(st_q.st)};
	endproperty
	a_rd: assert property (p_rd) else $error("state readback wrong"); // charge state code readback at 05H
	c_trk: cover property (@(posedge clock_i) chg_state_o == CPPS_TRICKLE);
	c_quick: cover property (@(posedge clock_i) chg_state_o == CPPS_QUICK);
	c_err: cover property (@(posedge clock_i) chg_state_o == CPPS_ERR1);
endmodule

/* File: bench/cpps_source_model.sv */
`timescale 1ns/10ps
module cpps_source_model import cpps_pkg::*; #(
	parameter int V_START = 2000,
	parameter int V_QC = 3000,
	parameter int V_OV = 4350,
	parameter int V_WEAK = 3400,
	parameter int V_GOOD = 3500,
	parameter int DET_CYC = 10
) (
	input wire logic clock_i,
	input wire logic vin_on_i,
	input wire logic vin_sag_i,
	input wire logic [12:0] vbat_mv_i,
	input wire logic th_con_i,
	input wire logic redet_i,
	input wire cpps_port_e kind_i,
	output cpps_cmp_s cmp_o,
	output logic det_busy_o,
	output logic det_done_o,
	output cpps_port_e port_o
);
	int cnt = 0;
	logic vin_q = 1'b0;
	// Comparator levels from source and battery voltages
	always_comb begin
		cmp_o.vin_ok = vin_on_i;
		cmp_o.vin_hl = vin_on_i && vin_sag_i;
		cmp_o.vbat_start = vbat_mv_i > V_START;
		cmp_o.vbat_qc = vbat_mv_i >= V_QC;
		cmp_o.vbat_ov = vbat_mv_i >= V_OV;
		cmp_o.vbat_weak = vbat_mv_i < V_WEAK;
		cmp_o.vbat_good = vbat_mv_i > V_GOOD;
		cmp_o.th_con = th_con_i;
		cmp_o.bat_short = vbat_mv_i < 100;
	end
	assign port_o = kind_i;
	assign det_busy_o = (cnt != 0);
	initial det_done_o = 1'b0;
	// Port detection after input rise or a redetect request
	always @(posedge clock_i) begin
		det_done_o <= 1'b0;
		vin_q <= vin_on_i;
		if (!vin_on_i) begin
			cnt <= 0;
		end else if (!vin_q || redet_i) begin
			cnt <= DET_CYC;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
			det_done_o <= (cnt == 1);
		end
	end
endmodule

/* File: bench/test_charge_power_path_sequencer.sv */
`timescale 1ns/10ps
`include "cpps_consts.svh"
module test_charge_power_path_sequencer import cpps_pkg::*;;
	logic clock_i = 0;
	logic sys_rst_i = 1;
	logic [7:0] addr = 0, wdata = 0, rdata, d;
	logic wr_s = 0, rd_s = 0, cen_n = 0, vin_on = 0, sag = 0, th = 0;
	logic [12:0] vbat = 0;
	logic busy, done, gate_n, pok_n, redet, dbp;
	cpps_port_e kind = CPPS_PORT_SDP;
	cpps_port_e port;
	cpps_cmp_s cmp;
	cpps_path_s path;
	cpps_state_e st;
	int err_total = 0, cmp_count = 0, redet_seen = 0, redet_base = 0;

	always #10 clock_i = ~clock_i;

	cpps_source_model i_src (.clock_i(clock_i), .vin_on_i(vin_on), .vin_sag_i(sag),
		.vbat_mv_i(vbat), .th_con_i(th), .redet_i(redet), .kind_i(kind), .cmp_o(cmp),
		.det_busy_o(busy), .det_done_o(done), .port_o(port));

	cpps_top #(.WEAK_CYC(30), .TRK_CYC(60), .FORCE_CYC(20)) i_dut (.clock_i(clock_i),
		.sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s),
		.reg_rd_i(rd_s), .reg_rdata_o(rdata), .cmp_i(cmp), .usb_det_busy_i(busy),
		.usb_det_done_i(done), .port_kind_i(port), .charge_enable_n_i(cen_n),
		.system_load_switch_gate_n_o(gate_n), .input_power_good_n_o(pok_n),
		.usb_redetect_o(redet), .dbp_active_o(dbp), .path_o(path), .chg_state_o(st));

	// Count redetect pulses
	always @(posedge clock_i) begin
		if (redet === 1'b1) redet_seen <= redet_seen + 1;
	end

	task automatic tally_and_finish;
		if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock_i) begin
			addr <= a;
			wdata <= v;
			wr_s <= 1'b1;
		end
		@(posedge clock_i) wr_s <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clock_i) begin
			addr <= a;
			rd_s <= 1'b1;
		end
		@(posedge clock_i) rd_s <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		check(v, exp);
	endtask

	// Read one status bit of the state register
	task automatic chk_bit(input int b, input logic exp);
		logic [7:0] v;
		rd(`CPPS_ADR_STATE, v);
		check({7'h0, v[b]}, {7'h0, exp});
	endtask

	// Wait up to 300 cycles for a charge state, then check the code read from register 05H
	task automatic await_state(input cpps_state_e s);
		int n;
		n = 0;
		while (st !== s && n < 300) begin
			@(posedge clock_i);
			n++;
		end
		chk_reg(`CPPS_ADR_SEQ, {4'h0, s});
	endtask

	task automatic settle;
		repeat (6) @(posedge clock_i);
	endtask

	initial begin
		repeat (3) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		// Reset values and an unmapped place
		chk_reg(`CPPS_ADR_CHG, `CPPS_RST_CHG);
		chk_reg(`CPPS_ADR_CTL, `CPPS_RST_CTL);
		chk_reg(`CPPS_ADR_SYS, `CPPS_RST_SYS);
		chk_reg(8'h0F, 8'h00);
		// Every input limit code except 6
		for (int k = 0; k < 8; k++) begin
			if (k != 6) begin
				wr(`CPPS_ADR_CTL, {4'h1, 3'(k), 1'b0});
				settle();
				check({5'h0, path.lim_sel}, {5'h0, 3'(k)});
			end
		end
		// Timer field off so the weak timer cannot suspend here
		wr(`CPPS_ADR_CTL, 8'h00);
		// Normal battery, trickle at 0.2C
		wr(`CPPS_ADR_CHG, 8'h59);
		vbat <= 13'd2500;
		vin_on <= 1'b1;
		settle();
		check({7'h0, gate_n}, 8'h01);
		check({7'h0, pok_n}, 8'h00);
		await_state(CPPS_FORCED);
		check({7'h0, path.trickle_02c}, 8'h01);
		await_state(CPPS_TRICKLE);
		// Overload during trickle
		sag <= 1'b1;
		settle();
		chk_bit(`CPPS_OVL_BIT, 1'b1);
		check({7'h0, path.freeze}, 8'h01);
		check({7'h0, path.chg_on}, 8'h00);
		sag <= 1'b0;
		vbat <= 13'd3100;
		await_state(CPPS_QUICK);
		cen_n <= 1'b1;
		vbat <= 13'd2500;
		await_state(CPPS_DEFAULT);
		cen_n <= 1'b0;
		await_state(CPPS_TRICKLE);
		vbat <= 13'd4400;
		await_state(CPPS_ERR1);
		chk_bit(`CPPS_VBATH_BIT, 1'b1);
		cen_n <= 1'b1;
		vbat <= 13'd2500;
		await_state(CPPS_DEFAULT);
		cen_n <= 1'b0;
		await_state(CPPS_TRICKLE);
		await_state(CPPS_ERR1);
		vbat <= 13'd1000;
		settle();
		chk_bit(`CPPS_BATTERY_ABSENT_FLAG_BIT, 1'b1);
		cen_n <= 1'b1;
		vin_on <= 1'b0;
		settle();
		check({7'h0, pok_n}, 8'h01);
		// Weak battery on a charging port
		cen_n <= 1'b0;
		vbat <= 13'd3000;
		kind <= CPPS_PORT_CHG;
		vin_on <= 1'b1;
		repeat (30) @(posedge clock_i);
		check({7'h0, dbp}, 8'h01);
		check({7'h0, gate_n}, 8'h01);
		redet_base = redet_seen;
		vbat <= 13'd3600;
		repeat (30) @(posedge clock_i);
		check(8'(redet_seen != redet_base), 8'h01);
		vin_on <= 1'b0;
		// Weak battery on a divided port
		kind <= CPPS_PORT_DIV;
		vbat <= 13'd3000;
		settle();
		vin_on <= 1'b1;
		repeat (30) @(posedge clock_i);
		check({7'h0, gate_n}, 8'h01);
		vbat <= 13'd3600;
		settle();
		check({7'h0, gate_n}, 8'h00);
		vbat <= 13'd3000;
		settle();
		check({7'h0, gate_n}, 8'h01);
		chk_bit(`CPPS_GDBAT_BIT, 1'b0);
		vin_on <= 1'b0;
		// Weak timer on a standard port ends in suspend
		kind <= CPPS_PORT_SDP;
		wr(`CPPS_ADR_CTL, `CPPS_RST_CTL);
		settle();
		vin_on <= 1'b1;
		repeat (80) @(posedge clock_i);
		check({5'h0, path.lim_sel}, 8'h07);
		tally_and_finish();
	end

	// Cut a hang short
	initial begin
		repeat (20000) @(posedge clock_i);
		err_total++;
		tally_and_finish();
	end
endmodule
